// ===== verilog/ppm_cfg.svh
`ifndef PPM_CFG_SVH
`define PPM_CFG_SVH

// Slot numbers of the process image
`define PPM_SLOT_KEYS_LO     3'h1
`define PPM_SLOT_KEYS_HI     3'h2
`define PPM_SLOT_INPUTS_LO   3'h3
`define PPM_SLOT_IO_HI       3'h4
`define PPM_SLOT_SAFETY      3'h5

// Input byte offsets within a slot
`define PPM_KEYS_LOW_BYTE0    3'h0
`define PPM_KEYS_LOW_BYTE1    3'h1
`define PPM_KEYS_HIGH_BYTE0   3'h0
`define PPM_KEYS_HIGH_BYTE1   3'h1
`define PPM_INPUTS_LOW_BYTE0  3'h0
`define PPM_INPUTS_LOW_BYTE1  3'h1
`define PPM_INPUTS_HIGH_BYTE0 3'h0
`define PPM_INPUTS_HIGH_BYTE1 3'h1
`define PPM_SAFETY_RESULT_BYTE 3'h0

// Output byte offsets within a slot
`define PPM_LAMPS_A_RED      3'h0
`define PPM_LAMPS_B_RED      3'h3
`define PPM_LAMPS_C_RED      3'h0
`define PPM_LAMPS_D_RED      3'h3
`define PPM_OUTPUTS_HIGH_BYTE0 3'h0
`define PPM_OUTPUTS_HIGH_BYTE1 3'h1
`define PPM_LAMP_SLOT_BYTES  3'h6
`define PPM_STD_SLOT_BYTES   3'h2

// Safety image size in bytes
`define PPM_SAFE_IN_BYTES    3'h5
`define PPM_SAFE_OUT_BYTES   3'h4

// Safety result bit positions
`define PPM_SAFE_STOP_A      0
`define PPM_SAFE_STOP_B      1
`define PPM_SAFE_SENSOR_A    4
`define PPM_SAFE_SENSOR_C    6

// Output image memory layout
`define PPM_IDX_LAMPS_SLOT1  4'h0
`define PPM_IDX_LAMPS_SLOT2  4'h6
`define PPM_IDX_OUTS_HI      4'hC
`define PPM_IMG_DEPTH        16

// Reset values
`define PPM_BYTE_RST         8'h00
`define PPM_WORD_RST         32'h0000_0000

// Stop channel discrepancy time
`define PPM_CLK_MHZ          200
`define PPM_DISC_TIME_US     500
`define PPM_DISC_CYCLES      (`PPM_DISC_TIME_US * `PPM_CLK_MHZ)

`endif

// ===== verilog/ppm_pkg.sv
package ppm_pkg;

	typedef enum logic [1:0] {
		PPM_PAIR_OFF    = 2'b00,
		PPM_PAIR_SINGLE = 2'b01,
		PPM_PAIR_DUAL   = 2'b10
	} ppm_pair_mode_t;

	typedef enum logic [1:0] {
		PPM_STOP_OPEN  = 2'b00,
		PPM_STOP_OK    = 2'b01,
		PPM_STOP_DISC  = 2'b10,
		PPM_STOP_FAULT = 2'b11
	} ppm_stop_state_t;

endpackage

// ===== verilog/ppm_img_mem.sv
`timescale 1ns/1ps
`include "ppm_cfg.svh"

module ppm_img_mem
(
	// Clock and reset
	input  wire logic         clock_in,
	input  wire logic         rst_b_in,
	// Write port
	input  wire logic         wr_en_in,
	input  wire logic [3:0]   wr_idx_in,
	input  wire logic [7:0]   wr_data_in,
	// Whole image, registered
	output logic      [127:0] image_out
);

	logic [7:0] mem_r [`PPM_IMG_DEPTH];

	genvar gi;
	generate
		for (gi = 0; gi < `PPM_IMG_DEPTH; gi++)
		begin : g_entry
			always_ff @(posedge clock_in or negedge rst_b_in)
			begin
				if (!rst_b_in)
					mem_r[gi] <= `PPM_BYTE_RST;
				else if (wr_en_in && (wr_idx_in == 4'(gi)))
					mem_r[gi] <= wr_data_in;
			end
			assign image_out[8*gi +: 8] = mem_r[gi];
		end
	endgenerate

endmodule

// ===== verilog/ppm_top.sv
`timescale 1ns/1ps
`include "ppm_cfg.svh"

module ppm_top
#(
	parameter int DISC_CYCLES = `PPM_DISC_CYCLES
)
(
	// Clock and reset
	input  wire logic        clock_in,
	input  wire logic        rst_b_in,
	// Panel keys and plain inputs
	input  wire logic [31:0] key_in,
	input  wire logic [31:0] plain_input_bit_in,
	input  wire logic [31:0] safe_claim_mask_in,
	// Fail-safe inputs
	input  wire logic        safety_input_zero_in,
	input  wire logic        safety_input_one_in,
	input  wire logic        safety_input_two_in,
	input  wire logic        safety_input_three_in,
	// Safety slot configuration
	input  wire logic        safe_cfg_valid_in,
	input  wire logic [1:0]  pair_a_mode_in,
	input  wire logic [1:0]  pair_b_mode_in,
	// Process image port from the controller
	input  wire logic        pi_wr_in,
	input  wire logic        pi_rd_in,
	input  wire logic [2:0]  pi_slot_in,
	input  wire logic [2:0]  pi_byte_in,
	input  wire logic [7:0]  pi_wdata_in,
	output logic      [7:0]  pi_rdata_out,
	output logic             pi_rvalid_out,
	output logic             pi_err_out,
	// LED drive
	output logic      [31:0] led_red_out,
	output logic      [31:0] led_green_out,
	output logic      [31:0] led_blue_out,
	// Digital outputs 16 to 31
	output logic      [15:0] plain_output_out,
	// Safety result byte
	output logic      [7:0]  safety_result_out
);

	localparam int CW = $clog2(DISC_CYCLES + 1);

	// Sampled input images
	logic [31:0] keys_r;
	logic [31:0] plain_r;
	logic [3:0]  safe_in_r;
	logic [7:0]  safe_result_r;
	logic [7:0]  safe_result_nxt;

	// Answer registers
	logic [7:0]  rdata_r;
	logic        rvalid_r;
	logic        err_r;
	logic [31:0] led_red_r;
	logic [31:0] led_green_r;
	logic [31:0] led_blue_r;
	logic [15:0] outs_r;

	// Standard images sampled on their own, blind to safety state
	always_ff @(posedge clock_in or negedge rst_b_in)
	begin
		if (!rst_b_in)
		begin
			keys_r    <= `PPM_WORD_RST;
			plain_r   <= `PPM_WORD_RST;
			safe_in_r <= 4'h0;
		end
		else
		begin
			keys_r    <= key_in;
			plain_r   <= plain_input_bit_in & ~safe_claim_mask_in;
			safe_in_r <= {safety_input_three_in, safety_input_two_in,
				safety_input_one_in, safety_input_zero_in};
		end
	end

	// Safety configuration decode
	wire ppm_pkg::ppm_pair_mode_t mode_a = ppm_pkg::ppm_pair_mode_t'(pair_a_mode_in);
	wire ppm_pkg::ppm_pair_mode_t mode_b = ppm_pkg::ppm_pair_mode_t'(pair_b_mode_in);
	wire a_single = (mode_a == ppm_pkg::PPM_PAIR_SINGLE);
	wire a_dual   = (mode_a == ppm_pkg::PPM_PAIR_DUAL);
	wire b_off    = (mode_b == ppm_pkg::PPM_PAIR_OFF);
	wire b_single = (mode_b == ppm_pkg::PPM_PAIR_SINGLE);
	wire b_dual   = (mode_b == ppm_pkg::PPM_PAIR_DUAL);

	// Only the documented pairings evaluate; anything else reads zero
	// Pair b in stop mode beside pair a single is not a legal pairing
	wire combo_ok = (a_single && b_off) || (a_dual && b_off) || (a_dual && b_dual) ||
		(a_dual && b_single) || (a_single && b_single);
	wire eval_on  = safe_cfg_valid_in && combo_ok;

	// Two emergency stop evaluators, one per channel pair
	logic [1:0] stop_ok;
	wire  [1:0] pair_dual = {b_dual, a_dual};

	genvar gp;
	generate
		for (gp = 0; gp < 2; gp++)
		begin : g_stop
			ppm_pkg::ppm_stop_state_t st_r;
			ppm_pkg::ppm_stop_state_t st_nxt;
			logic [CW-1:0] cnt_r;
			wire ch_a    = safe_in_r[2*gp];
			wire ch_b    = safe_in_r[2*gp+1];
			wire both_cl = ch_a && ch_b;
			wire both_op = !ch_a && !ch_b;
			wire active  = eval_on && pair_dual[gp];
			wire timeout = (cnt_r >= CW'(DISC_CYCLES - 1));

			// A channel mismatch that outlasts the window latches a fault
			// Sticky on purpose: a half-wired button must be opened fully
			always_comb
			begin
				st_nxt = st_r;
				case (st_r)
					ppm_pkg::PPM_STOP_OPEN:
					begin
						if (both_cl)
							st_nxt = ppm_pkg::PPM_STOP_OK;
						else if (!both_op)
							st_nxt = ppm_pkg::PPM_STOP_DISC;
					end
					ppm_pkg::PPM_STOP_OK:
					begin
						if (both_op)
							st_nxt = ppm_pkg::PPM_STOP_OPEN;
						else if (!both_cl)
							st_nxt = ppm_pkg::PPM_STOP_DISC;
					end
					ppm_pkg::PPM_STOP_DISC:
					begin
						if (both_op)
							st_nxt = ppm_pkg::PPM_STOP_OPEN;
						else if (both_cl)
							st_nxt = ppm_pkg::PPM_STOP_OK;
						else if (timeout)
							st_nxt = ppm_pkg::PPM_STOP_FAULT;
					end
					ppm_pkg::PPM_STOP_FAULT:
					begin
						// Needs both channels open before re-arming
						if (both_op)
							st_nxt = ppm_pkg::PPM_STOP_OPEN;
					end
					default:
						st_nxt = ppm_pkg::PPM_STOP_OPEN;
				endcase
			end

			always_ff @(posedge clock_in or negedge rst_b_in)
			begin
				if (!rst_b_in)
					st_r <= ppm_pkg::PPM_STOP_OPEN;
				else if (!active)
					st_r <= ppm_pkg::PPM_STOP_OPEN;
				else
					st_r <= st_nxt;
			end

			always_ff @(posedge clock_in or negedge rst_b_in)
			begin
				if (!rst_b_in)
					cnt_r <= '0;
				else if (active && (st_r == ppm_pkg::PPM_STOP_DISC) && !timeout)
					cnt_r <= cnt_r + CW'(1);
				else if (st_r != ppm_pkg::PPM_STOP_DISC)
					cnt_r <= '0;
			end

			// Pressed, mismatch or fault all read as zero
			assign stop_ok[gp] = active && (st_r == ppm_pkg::PPM_STOP_OK);
		end
	endgenerate

	// Result byte assembly per mode; unused bits stay zero
	wire       sens_a = eval_on && a_single;
	wire       sens_b = eval_on && b_single;
	wire [1:0] sens_a_bits = sens_a ? safe_in_r[1:0] : 2'h0;
	wire [1:0] sens_b_bits = sens_b ? safe_in_r[3:2] : 2'h0;

	always_comb
	begin
		safe_result_nxt = `PPM_BYTE_RST;
		safe_result_nxt[`PPM_SAFE_STOP_A] = stop_ok[0];
		safe_result_nxt[`PPM_SAFE_STOP_B] = stop_ok[1];
		safe_result_nxt[`PPM_SAFE_SENSOR_A +: 2] = sens_a_bits;
		safe_result_nxt[`PPM_SAFE_SENSOR_C +: 2] = sens_b_bits;
	end

	always_ff @(posedge clock_in or negedge rst_b_in)
	begin
		if (!rst_b_in)
			safe_result_r <= `PPM_BYTE_RST;
		else
			safe_result_r <= safe_result_nxt;
	end

	// Read decode of the input images
	wire sel_k_lo = (pi_slot_in == `PPM_SLOT_KEYS_LO);
	wire sel_k_hi = (pi_slot_in == `PPM_SLOT_KEYS_HI);
	wire sel_i_lo = (pi_slot_in == `PPM_SLOT_INPUTS_LO);
	wire sel_i_hi = (pi_slot_in == `PPM_SLOT_IO_HI);
	wire sel_safe = (pi_slot_in == `PPM_SLOT_SAFETY);
	wire std_byte = (pi_byte_in < `PPM_STD_SLOT_BYTES);
	wire hi_byte  = (pi_byte_in == `PPM_KEYS_LOW_BYTE1);

	wire [15:0] slot_word =
		sel_k_lo ? keys_r[15:0]  :
		sel_k_hi ? keys_r[31:16] :
		sel_i_lo ? plain_r[15:0] :
		sel_i_hi ? plain_r[31:16] :
		16'h0000;
	wire [7:0] std_rd = hi_byte ? slot_word[15:8] : slot_word[7:0];

	// Protocol bytes 1 to 4 belong to the safety layer and read zero here
	wire safe_rd_ok = sel_safe && (pi_byte_in < `PPM_SAFE_IN_BYTES);
	wire [7:0] safe_rd =
		(pi_byte_in == `PPM_SAFETY_RESULT_BYTE) ? safe_result_r : 8'h00;

	wire rd_std_ok = (sel_k_lo || sel_k_hi || sel_i_lo || sel_i_hi) && std_byte;
	wire rd_ok     = rd_std_ok || safe_rd_ok;
	wire [7:0] rd_data = rd_std_ok ? std_rd : (safe_rd_ok ? safe_rd : 8'h00);

	// Write decode into the output image
	wire wr_lamp1 = (pi_slot_in == `PPM_SLOT_KEYS_LO) && (pi_byte_in < `PPM_LAMP_SLOT_BYTES);
	wire wr_lamp2 = (pi_slot_in == `PPM_SLOT_KEYS_HI) && (pi_byte_in < `PPM_LAMP_SLOT_BYTES);
	wire wr_outs  = sel_i_hi && std_byte;
	wire wr_ok    = wr_lamp1 || wr_lamp2 || wr_outs;
	wire [3:0] wr_base =
		wr_lamp1 ? `PPM_IDX_LAMPS_SLOT1 :
		wr_lamp2 ? `PPM_IDX_LAMPS_SLOT2 :
		`PPM_IDX_OUTS_HI;
	wire [3:0] wr_idx = wr_base + {1'b0, pi_byte_in};
	wire [127:0] image;

	// Safety output bytes go to the safety layer, so a write there is refused
	ppm_img_mem u_img
	(
		.clock_in   (clock_in),
		.rst_b_in   (rst_b_in),
		.wr_en_in   (pi_wr_in && wr_ok),
		.wr_idx_in  (wr_idx),
		.wr_data_in (pi_wdata_in),
		.image_out  (image)
	);

	// A read that meets a write in one cycle is dropped, data stays zero
	wire rd_only = pi_rd_in && !pi_wr_in;

	// Read answer, one cycle after the strobe; write wins error reporting
	always_ff @(posedge clock_in or negedge rst_b_in)
	begin
		if (!rst_b_in)
		begin
			rdata_r  <= `PPM_BYTE_RST;
			rvalid_r <= 1'b0;
			err_r    <= 1'b0;
		end
		else
		begin
			rdata_r  <= rd_only ? rd_data : 8'h00;
			rvalid_r <= rd_only;
			err_r    <= pi_wr_in ? !wr_ok : (pi_rd_in && !rd_ok);
		end
	end

	// Per LED colour decode, LED index modulo 8 picks the bit
	// Decoded before the flops, so the pins never show a blanked pair
	logic [31:0] red_nxt;
	logic [31:0] green_nxt;
	logic [31:0] blue_nxt;

	genvar gl;
	generate
		for (gl = 0; gl < 32; gl++)
		begin : g_led
			localparam int BASE = (gl / 8) * 3;
			wire r = image[8*BASE + (gl % 8)];
			wire g = image[8*(BASE+1) + (gl % 8)];
			wire b = image[8*(BASE+2) + (gl % 8)];
			// Red+blue and green+blue have no colour of their own
			wire blank = b && (r ^ g);
			assign red_nxt[gl]   = r && !blank;
			assign green_nxt[gl] = g && !blank;
			assign blue_nxt[gl]  = b && !blank;
		end
	endgenerate

	always_ff @(posedge clock_in or negedge rst_b_in)
	begin
		if (!rst_b_in)
		begin
			led_red_r   <= `PPM_WORD_RST;
			led_green_r <= `PPM_WORD_RST;
			led_blue_r  <= `PPM_WORD_RST;
			outs_r      <= 16'h0000;
		end
		else
		begin
			led_red_r   <= red_nxt;
			led_green_r <= green_nxt;
			led_blue_r  <= blue_nxt;
			outs_r      <= image[8*`PPM_IDX_OUTS_HI +: 16];
		end
	end

	// Port drive; process data framing is the protocol stack's job
	assign pi_rdata_out      = rdata_r;
	assign pi_rvalid_out     = rvalid_r;
	assign pi_err_out        = err_r;
	assign led_red_out       = led_red_r;
	assign led_green_out     = led_green_r;
	assign led_blue_out      = led_blue_r;
	assign plain_output_out  = outs_r;
	assign safety_result_out = safe_result_r;

endmodule

// ===== verification/ppm_top_sva.sv
`timescale 1ns/1ps

module ppm_top_sva
(
	// Clock and reset
	input  wire logic        clock_in,
	input  wire logic        rst_b_in,
	// Watched inputs
	input  wire logic [31:0] key_in,
	input  wire logic [31:0] safe_claim_mask_in,
	input  wire logic        safety_input_zero_in,
	input  wire logic        safety_input_one_in,
	input  wire logic        safety_input_two_in,
	input  wire logic        safety_input_three_in,
	input  wire logic        safe_cfg_valid_in,
	input  wire logic [1:0]  pair_a_mode_in,
	input  wire logic [1:0]  pair_b_mode_in,
	input  wire logic        pi_wr_in,
	input  wire logic        pi_rd_in,
	input  wire logic [2:0]  pi_slot_in,
	input  wire logic [2:0]  pi_byte_in,
	// Watched outputs
	input  wire logic [7:0]  pi_rdata_out,
	input  wire logic        pi_rvalid_out,
	input  wire logic        pi_err_out,
	input  wire logic [7:0]  safety_result_out
);
	default clocking @(posedge clock_in); endclocking
	default disable iff (!rst_b_in);

	logic [3:0] fs;
	logic       cv;
	logic       rd_only;
	assign fs = {safety_input_three_in, safety_input_two_in, safety_input_one_in,
		safety_input_zero_in};
	assign cv = safe_cfg_valid_in;
	assign rd_only = pi_rd_in && !pi_wr_in;

	// Stop bits wait for the slower stop path, hence the longer hold on the stop checks
	AST_RESULT_OFF: assert property (!cv [*4] |-> safety_result_out == 8'h00)
		else $error("Safety result not zero while unconfigured");
	AST_SPARE_BITS: assert property (safety_result_out[3:2] == 2'h0)
		else $error("Unused result bits set");
	AST_ONE_A: assert property ((cv && pair_a_mode_in == 2'h1 && pair_b_mode_in == 2'h0
		&& $stable(fs)) [*4] |-> safety_result_out == {2'h0, fs[1:0], 4'h0})
		else $error("Single contacts wrong in bits 4 and 5");
	AST_ONE_AB: assert property ((cv && pair_a_mode_in == 2'h1 && pair_b_mode_in == 2'h1
		&& $stable(fs)) [*4] |-> safety_result_out == {fs, 4'h0})
		else $error("Four contacts wrong in bits 4 to 7");
	AST_STOP_A_OPEN: assert property ((cv && pair_a_mode_in == 2'h2
		&& !(fs[0] && fs[1])) [*5] |-> !safety_result_out[0])
		else $error("Stop bit 0 set with a channel open");
	AST_STOP_B_OPEN: assert property ((cv && pair_b_mode_in == 2'h2
		&& !(fs[2] && fs[3])) [*5] |-> !safety_result_out[1])
		else $error("Stop bit 1 set with a channel open");
	AST_STOP_MIX: assert property ((cv && pair_a_mode_in == 2'h2 && pair_b_mode_in == 2'h1
		&& $stable(fs)) [*4] |-> safety_result_out[7:6] == fs[3:2]
		&& safety_result_out[5:1] == 5'h00)
		else $error("Mixed mode result wrong");
	AST_RD_ANSWER: assert property (rd_only |=> pi_rvalid_out || pi_err_out)
		else $error("Read not answered after one cycle");
	AST_WR_QUIET: assert property (pi_wr_in |=> !pi_rvalid_out)
		else $error("Write gave read valid");
	AST_RDATA_IDLE: assert property (!pi_rvalid_out |-> pi_rdata_out == 8'h00)
		else $error("Read data not zero while idle");
	AST_KEY_LOW: assert property (rd_only && pi_slot_in == 3'h1 && pi_byte_in == 3'h0
		&& $stable(key_in[7:0]) |=> pi_rdata_out == $past(key_in[7:0], 2))
		else $error("Keys 0 to 7 read wrong");
	AST_CLAIM: assert property (rd_only && pi_slot_in == 3'h3 && pi_byte_in == 3'h0
		&& $stable(safe_claim_mask_in[7:0])
		|=> (pi_rdata_out & $past(safe_claim_mask_in[7:0], 2)) == 8'h00)
		else $error("Claimed input shown in standard image");
	AST_SAFE_WR: assert property (pi_wr_in && pi_slot_in == 3'h5 |=> pi_err_out)
		else $error("Safety output write not refused");
endmodule

bind ppm_top ppm_top_sva i_ppm_top_sva
(
	.clock_in,
	.rst_b_in,
	.key_in,
	.safe_claim_mask_in,
	.safety_input_zero_in,
	.safety_input_one_in,
	.safety_input_two_in,
	.safety_input_three_in,
	.safe_cfg_valid_in,
	.pair_a_mode_in,
	.pair_b_mode_in,
	.pi_wr_in,
	.pi_rd_in,
	.pi_slot_in,
	.pi_byte_in,
	.pi_rdata_out,
	.pi_rvalid_out,
	.pi_err_out,
	.safety_result_out
);

// ===== verification/ppm_ctrl_model.sv
`timescale 1ns/1ps

module ppm_ctrl_model
(
	// Clock
	input  wire logic       clock_in,
	// Process image port
	output logic            pi_wr_out,
	output logic            pi_rd_out,
	output logic      [2:0] pi_slot_out,
	output logic      [2:0] pi_byte_out,
	output logic      [7:0] pi_wdata_out,
	input  wire logic [7:0] pi_rdata_in,
	input  wire logic       pi_rvalid_in,
	input  wire logic       pi_err_in
);
	initial
	begin
		pi_wr_out = 1'b0;
		pi_rd_out = 1'b0;
		pi_slot_out = 3'h0;
		pi_byte_out = 3'h0;
		pi_wdata_out = 8'h00;
	end

	// One byte per cyclic exchange; a plain controller, no safety layer
	task automatic xfer(input logic w, input logic [2:0] s, input logic [2:0] b,
		input logic [7:0] wd, output logic [7:0] d, output logic e, output logic to);
		@(posedge clock_in);
		pi_wr_out <= w;
		pi_rd_out <= !w;
		pi_slot_out <= s;
		pi_byte_out <= b;
		pi_wdata_out <= wd;
		@(posedge clock_in);
		pi_wr_out <= 1'b0;
		pi_rd_out <= 1'b0;
		#1;
		d = pi_rdata_in;
		e = pi_err_in;
		to = !(w || pi_rvalid_in || pi_err_in);
	endtask
endmodule

// ===== verification/panel_process_image_map_tb_top.sv
`timescale 1ns/1ps

module panel_process_image_map_tb_top;
	typedef struct packed {
		logic [2:0]  s;
		logic [2:0]  b;
		logic [31:0] m;
		logic [7:0]  d;
		logic        e;
	} ppm_row_t;

	logic        clock_in = 1'b0;
	logic        rst_b_in = 1'b0;
	logic [31:0] key_in = 32'h8421_C301;
	logic [31:0] plain_input_bit_in = 32'h1234_5678;
	logic [31:0] safe_claim_mask_in = 32'h0000_0000;
	logic [3:0]  fi = 4'h0;
	logic        safe_cfg_valid_in = 1'b0;
	logic [1:0]  pair_a_mode_in = 2'h0;
	logic [1:0]  pair_b_mode_in = 2'h0;
	logic        pi_wr, pi_rd, pi_rvalid, pi_err;
	logic [2:0]  pi_slot, pi_byte;
	logic [7:0]  pi_wdata, pi_rdata, safety_result_out, rd_d;
	logic [31:0] led_red, led_green, led_blue;
	logic [15:0] plain_output;
	logic        rd_e, rd_to;
	int          num_errors = 0;
	int          n_checks = 0;
	logic [7:0]  pat [3] = '{8'hAA, 8'hCC, 8'hF0};
	ppm_row_t    rows [15] = '{
		'{3'h1, 3'h0, 32'h0, 8'h01, 1'b0}, '{3'h1, 3'h1, 32'h0, 8'hC3, 1'b0},
		'{3'h2, 3'h0, 32'h0, 8'h21, 1'b0}, '{3'h2, 3'h1, 32'h0, 8'h84, 1'b0},
		'{3'h3, 3'h0, 32'h0, 8'h78, 1'b0}, '{3'h3, 3'h1, 32'h0, 8'h56, 1'b0},
		'{3'h4, 3'h0, 32'h0, 8'h34, 1'b0}, '{3'h4, 3'h1, 32'h0, 8'h12, 1'b0},
		'{3'h3, 3'h0, 32'hF0, 8'h08, 1'b0}, '{3'h4, 3'h1, 32'hFF00_0000, 8'h00, 1'b0},
		'{3'h5, 3'h0, 32'h0, 8'h00, 1'b0}, '{3'h5, 3'h4, 32'h0, 8'h00, 1'b0},
		'{3'h5, 3'h5, 32'h0, 8'h00, 1'b1}, '{3'h1, 3'h2, 32'h0, 8'h00, 1'b1},
		'{3'h0, 3'h0, 32'h0, 8'h00, 1'b1}};

	ppm_top #(.DISC_CYCLES(8)) i_ppm_top
	(
		.clock_in(clock_in), .rst_b_in(rst_b_in), .key_in(key_in),
		.plain_input_bit_in(plain_input_bit_in), .safe_claim_mask_in(safe_claim_mask_in),
		.safety_input_zero_in(fi[0]), .safety_input_one_in(fi[1]),
		.safety_input_two_in(fi[2]), .safety_input_three_in(fi[3]),
		.safe_cfg_valid_in(safe_cfg_valid_in), .pair_a_mode_in(pair_a_mode_in),
		.pair_b_mode_in(pair_b_mode_in), .pi_wr_in(pi_wr), .pi_rd_in(pi_rd),
		.pi_slot_in(pi_slot), .pi_byte_in(pi_byte), .pi_wdata_in(pi_wdata),
		.pi_rdata_out(pi_rdata), .pi_rvalid_out(pi_rvalid), .pi_err_out(pi_err),
		.led_red_out(led_red), .led_green_out(led_green), .led_blue_out(led_blue),
		.plain_output_out(plain_output), .safety_result_out(safety_result_out)
	);

	ppm_ctrl_model i_ppm_ctrl_model
	(
		.clock_in(clock_in), .pi_wr_out(pi_wr), .pi_rd_out(pi_rd), .pi_slot_out(pi_slot),
		.pi_byte_out(pi_byte), .pi_wdata_out(pi_wdata), .pi_rdata_in(pi_rdata),
		.pi_rvalid_in(pi_rvalid), .pi_err_in(pi_err)
	);

	always #2.5 clock_in = ~clock_in;

	task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		n_checks++;
		if (seen !== exp)
		begin
			num_errors++;
			$display("[FAIL] %s expected %h seen %h", nm, exp, seen);
		end
	endtask

	task automatic stop_test;
		$display("Checks %0d, errors %0d", n_checks, num_errors);
		if (num_errors == 0 && n_checks > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask

	// A missing answer counts as a mismatch, not a hang
	task automatic px(input logic w, input logic [2:0] s, input logic [2:0] b,
		input logic [7:0] wd);
		i_ppm_ctrl_model.xfer(w, s, b, wd, rd_d, rd_e, rd_to);
		check("answer", rd_to, 1'b0);
	endtask

	task automatic sf(input logic c, input logic [1:0] a, input logic [1:0] b,
		input logic [3:0] f, input logic [7:0] exp);
		@(posedge clock_in);
		safe_cfg_valid_in <= c;
		pair_a_mode_in <= a;
		pair_b_mode_in <= b;
		fi <= f;
		repeat (6) @(posedge clock_in);
		#1;
		check("result", safety_result_out, exp);
		px(1'b0, 3'h5, 3'h0, 8'h00);
		check("slot5_byte0", rd_d, exp);
	endtask

	initial
	begin
		repeat (6) @(posedge clock_in);
		rst_b_in <= 1'b1;
		foreach (rows[i])
		begin
			@(posedge clock_in);
			safe_claim_mask_in <= rows[i].m;
			repeat (2) @(posedge clock_in);
			px(1'b0, rows[i].s, rows[i].b, 8'h00);
			check("rdata", rd_d, rows[i].d);
			check("rd_err", rd_e, rows[i].e);
		end
		for (int s = 1; s <= 2; s++)
			for (int b = 0; b < 6; b++)
			begin
				px(1'b1, s[2:0], b[2:0], pat[b % 3]);
				check("wr_err", rd_e, 1'b0);
			end
		px(1'b1, 3'h4, 3'h0, 8'h3C);
		px(1'b1, 3'h4, 3'h1, 8'hC3);
		px(1'b1, 3'h5, 3'h0, 8'hFF);
		check("safe_wr_err", rd_e, 1'b1);
		px(1'b1, 3'h3, 3'h0, 8'hFF);
		check("in_wr_err", rd_e, 1'b1);
		repeat (3) @(posedge clock_in);
		#1;
		// Red plus blue and green plus blue sit at bits 5 and 6 of each byte
		check("red", led_red, {4{8'h8A}});
		check("green", led_green, {4{8'h8C}});
		check("blue", led_blue, {4{8'h90}});
		check("outputs", plain_output, 16'hC33C);
		sf(1'b1, 2'h1, 2'h0, 4'b1110, 8'h20);
		sf(1'b1, 2'h1, 2'h1, 4'b1110, 8'hE0);
		sf(1'b1, 2'h2, 2'h0, 4'b0000, 8'h00);
		sf(1'b1, 2'h2, 2'h0, 4'b0011, 8'h01);
		sf(1'b1, 2'h2, 2'h2, 4'b0000, 8'h00);
		sf(1'b1, 2'h2, 2'h2, 4'b1111, 8'h03);
		sf(1'b1, 2'h2, 2'h1, 4'b0111, 8'h41);
		sf(1'b0, 2'h2, 2'h1, 4'b1111, 8'h00);
		sf(1'b1, 2'h2, 2'h0, 4'b0000, 8'h00);
		sf(1'b1, 2'h2, 2'h0, 4'b0001, 8'h00);
		sf(1'b1, 2'h2, 2'h0, 4'b0001, 8'h00);
		sf(1'b1, 2'h2, 2'h0, 4'b0011, 8'h00);
		sf(1'b1, 2'h2, 2'h0, 4'b0000, 8'h00);
		sf(1'b1, 2'h2, 2'h0, 4'b0011, 8'h01);
		sf(1'b1, 2'h1, 2'h2, 4'b1111, 8'h00);
		@(posedge clock_in);
		rst_b_in <= 1'b0;
		@(posedge clock_in);
		#1;
		check("rst_red", led_red, 32'h0000_0000);
		check("rst_result", safety_result_out, 8'h00);
		check("rst_outputs", plain_output, 16'h0000);
		@(posedge clock_in);
		rst_b_in <= 1'b1;
		px(1'b0, 3'h1, 3'h0, 8'h00);
		check("rst_keys", rd_d, 8'h01);
		stop_test();
	end
endmodule
